// ==== rtl/tpu_pkg.sv ====
// Shared constants for the five-channel timer/PWM unit
// **********************************************************************
// Summary of operation
// - Each channel counts with a 16-bit counter; software programs the period.
// - A capture input edge latches the current count into a readable capture register.
// - Count equal to period either halts the counter or reloads it, as configured.
// - Counter is compared with a compare register to form the PWM duty signal.
// - True and complementary outputs are separated by a programmable dead band.
// - Kill input forces both outputs to a preset safe state, with no software.
// - Five independent channels, each with own counter, period, capture and compare.
// **********************************************************************
package tpu_pkg;
    localparam int NUM_CH   = 5;
    localparam int CNT_W    = 16;
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int CH_SHIFT = 5;
    localparam int CTRL_W   = 4;

    // Register offsets inside one channel window of 0x20 bytes
    localparam logic [4:0] OFF_CTRL    = 5'h00;
    localparam logic [4:0] OFF_PERIOD  = 5'h04;
    localparam logic [4:0] OFF_COMPARE = 5'h08;
    localparam logic [4:0] OFF_DEAD    = 5'h0C;
    localparam logic [4:0] OFF_CAPTURE = 5'h10;
    localparam logic [4:0] OFF_COUNT   = 5'h14;
    localparam logic [4:0] OFF_STATUS  = 5'h18;

    // Control and status field positions
    localparam int CTRL_EN     = 0;
    localparam int CTRL_RELOAD = 1;
    localparam int CTRL_KILL_P = 2;
    localparam int CTRL_KILL_N = 3;
    localparam int STAT_HALTED = 0;
    localparam int STAT_KILL   = 1;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST    = 4'h0;
    localparam logic [CNT_W-1:0]  PERIOD_RST  = 16'hFFFF;
    localparam logic [CNT_W-1:0]  COMPARE_RST = 16'h0000;
    localparam logic [CNT_W-1:0]  DEAD_RST    = 16'h0000;
    localparam logic [CNT_W-1:0]  CNT_RST     = 16'h0000;
    localparam logic [CNT_W-1:0]  CNT_MAX     = 16'hFFFF;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== rtl/tpu_channel.sv ====
// One timer/counter/PWM channel with capture, dead band and kill
`timescale 1ns/1ns
module tpu_channel
    import tpu_pkg::*;
(
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Configuration
    input  wire logic             enable,
    input  wire logic             auto_reload,
    input  wire logic             kill_lvl_p,
    input  wire logic             kill_lvl_n,
    input  wire logic [tpu_pkg::CNT_W-1:0] period,
    input  wire logic [tpu_pkg::CNT_W-1:0] compare,
    input  wire logic [tpu_pkg::CNT_W-1:0] dead,
    // Events
    input  wire logic             capture_in,
    input  wire logic             kill_in,
    // State
    output logic [tpu_pkg::CNT_W-1:0]      count_r,
    output logic [tpu_pkg::CNT_W-1:0]      capture_r,
    output logic                  halted_r,
    // Pins
    output logic                  pwm_p_r,
    output logic                  pwm_n_r
);
    import tpu_pkg::*;

    logic [CNT_W-1:0] count_nxt;
    logic [CNT_W-1:0] capture_nxt;
    logic [CNT_W-1:0] dcnt_r;
    logic [CNT_W-1:0] dcnt_nxt;
    logic             halted_nxt;
    logic             cap_d_r;
    logic             raw_r;
    logic             raw_nxt;
    logic             pwm_p_nxt;
    logic             pwm_n_nxt;

    // **********************************************************************
    // Counter, capture and duty
    // **********************************************************************
    always_comb begin
        count_nxt  = count_r;
        halted_nxt = halted_r;
        if (!enable) begin
            count_nxt  = CNT_RST;
            halted_nxt = 1'b0;
        end else if (!halted_r) begin
            if (count_r == period) begin
                if (auto_reload) begin
                    count_nxt = CNT_RST;
                end else begin
                    halted_nxt = 1'b1;
                end
            end else begin
                count_nxt = count_r + 16'h0001;
            end
        end
        // Rising edge only, so a held input captures once
        capture_nxt = (capture_in && !cap_d_r) ? count_r : capture_r;
        raw_nxt     = enable && (count_r < compare);
    end

    // **********************************************************************
    // Dead band and kill
    // **********************************************************************
    always_comb begin
        if (raw_nxt != raw_r) begin
            dcnt_nxt = CNT_RST;
        end else if (dcnt_r == CNT_MAX) begin
            dcnt_nxt = dcnt_r;
        end else begin
            dcnt_nxt = dcnt_r + 16'h0001;
        end
        // Kill bypasses enable so a trip holds the stage safe in any mode
        if (kill_in) begin
            pwm_p_nxt = kill_lvl_p;
            pwm_n_nxt = kill_lvl_n;
        end else if (!enable) begin
            pwm_p_nxt = 1'b0;
            pwm_n_nxt = 1'b0;
        end else begin
            pwm_p_nxt = raw_r && (dcnt_r >= dead);
            pwm_n_nxt = !raw_r && (dcnt_r >= dead);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_r   <= CNT_RST;
            capture_r <= CNT_RST;
            halted_r  <= 1'b0;
            cap_d_r   <= 1'b0;
            raw_r     <= 1'b0;
            dcnt_r    <= CNT_RST;
            pwm_p_r   <= 1'b0;
            pwm_n_r   <= 1'b0;
        end else begin
            count_r   <= count_nxt;
            capture_r <= capture_nxt;
            halted_r  <= halted_nxt;
            cap_d_r   <= capture_in;
            raw_r     <= raw_nxt;
            dcnt_r    <= dcnt_nxt;
            pwm_p_r   <= pwm_p_nxt;
            pwm_n_r   <= pwm_n_nxt;
        end
    end

    // **********************************************************************
    // Checks
    // **********************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_COUNT: assert property (enable && !halted_r && count_r != period
        |=> count_r == $past(count_r) + 16'h0001) else $error("count did not step");
    AST_CAPTURE: assert property (capture_in && !cap_d_r
        |=> capture_r == $past(count_r)) else $error("capture missed count");
    AST_RELOAD: assert property (enable && !halted_r && count_r == period && auto_reload
        |=> count_r == CNT_RST && !halted_r) else $error("no reload at period");
    AST_HALT: assert property (enable && !halted_r && count_r == period && !auto_reload
        |=> halted_r && count_r == $past(count_r)) else $error("no halt at period");
    AST_DUTY: assert property (enable |=> raw_r == ($past(count_r) < $past(compare)))
        else $error("duty signal differs from compare result");
    AST_DEADBAND: assert property ($rose(raw_r) && dead != 16'h0000 && !kill_in
        |=> !pwm_p_r && !pwm_n_r) else $error("dead band missing");
    AST_KILL: assert property (kill_in |=> pwm_p_r == $past(kill_lvl_p)
        && pwm_n_r == $past(kill_lvl_n)) else $error("kill state not forced");
    AST_IDLE: assert property (!enable && !kill_in |=> !pwm_p_r && !pwm_n_r
        && count_r == CNT_RST) else $error("outputs active while disabled");

    COV_RELOAD:  cover property (enable && count_r == period && auto_reload ##1 count_r == 0);
    COV_HALT:    cover property ($rose(halted_r));
    COV_KILL:    cover property (enable && !kill_in ##1 kill_in);
    COV_CAPTURE: cover property (enable && capture_in && !cap_d_r);
endmodule

// ==== rtl/tpu_top.sv ====
// AXI4-Lite register block and five timer/PWM channels
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
module tpu_top
    import tpu_pkg::*;
(
    // Clock and reset
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // AXI4-Lite write address
    input  wire logic [tpu_pkg::ADDR_W-1:0]  awaddr,
    input  wire logic                        awvalid,
    output logic                             awready,
    // AXI4-Lite write data
    input  wire logic [tpu_pkg::DATA_W-1:0]  wdata,
    input  wire logic [3:0]                  wstrb,
    input  wire logic                        wvalid,
    output logic                             wready,
    // AXI4-Lite write response
    output logic [1:0]                       bresp,
    output logic                             bvalid,
    input  wire logic                        bready,
    // AXI4-Lite read address
    input  wire logic [tpu_pkg::ADDR_W-1:0]  araddr,
    input  wire logic                        arvalid,
    output logic                             arready,
    // AXI4-Lite read data
    output logic [tpu_pkg::DATA_W-1:0]       rdata,
    output logic [1:0]                       rresp,
    output logic                             rvalid,
    input  wire logic                        rready,
    // Channel pins
    input  wire logic [tpu_pkg::NUM_CH-1:0]  capture_in,
    input  wire logic [tpu_pkg::NUM_CH-1:0]  kill_in,
    output logic [tpu_pkg::NUM_CH-1:0]       pwm_out,
    output logic [tpu_pkg::NUM_CH-1:0]       pwm_n_out
);
    import tpu_pkg::*;

    typedef enum logic {TPU_RD_IDLE, TPU_RD_RESP} tpu_rd_e;

    // **********************************************************************
    // Address decode and byte-lane merge
    // **********************************************************************
    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        logic [4:0] off;
        off = a[CH_SHIFT-1:0];
        addr_ok = (a[ADDR_W-1:CH_SHIFT] < 3'(NUM_CH)) &&
                  (off == OFF_CTRL    || off == OFF_PERIOD ||
                   off == OFF_COMPARE || off == OFF_DEAD   ||
                   off == OFF_CAPTURE || off == OFF_COUNT  ||
                   off == OFF_STATUS);
    endfunction

    function automatic logic [DATA_W-1:0] merge(
        input logic [DATA_W-1:0] old_v,
        input logic [DATA_W-1:0] new_v,
        input logic [3:0]        strb
    );
        logic [DATA_W-1:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        merge = res;
    endfunction

    // **********************************************************************
    // Configuration registers
    // **********************************************************************
    logic [CTRL_W-1:0] ctrl_r     [NUM_CH];
    logic [CTRL_W-1:0] ctrl_nxt   [NUM_CH];
    logic [CNT_W-1:0]  period_r   [NUM_CH];
    logic [CNT_W-1:0]  period_nxt [NUM_CH];
    logic [CNT_W-1:0]  cmp_r      [NUM_CH];
    logic [CNT_W-1:0]  cmp_nxt    [NUM_CH];
    logic [CNT_W-1:0]  dead_r     [NUM_CH];
    logic [CNT_W-1:0]  dead_nxt   [NUM_CH];
    logic [CNT_W-1:0]  count_w    [NUM_CH];
    logic [CNT_W-1:0]  capture_w  [NUM_CH];
    logic [NUM_CH-1:0] halted_w;

    // **********************************************************************
    // Write channel
    // **********************************************************************
    logic              aw_got_r;
    logic              aw_got_nxt;
    logic              w_got_r;
    logic              w_got_nxt;
    logic [ADDR_W-1:0] wa_r;
    logic [ADDR_W-1:0] wa_nxt;
    logic [DATA_W-1:0] wd_r;
    logic [DATA_W-1:0] wd_nxt;
    logic [3:0]        ws_r;
    logic [3:0]        ws_nxt;
    logic              awready_nxt;
    logic              wready_nxt;
    logic              bvalid_nxt;
    logic [1:0]        bresp_nxt;
    logic              wr_exec;

    // Address and data are held until both arrived, in either order
    always_comb begin
        aw_got_nxt = aw_got_r;
        w_got_nxt  = w_got_r;
        wa_nxt     = wa_r;
        wd_nxt     = wd_r;
        ws_nxt     = ws_r;
        bvalid_nxt = bvalid;
        bresp_nxt  = bresp;
        wr_exec    = aw_got_r && w_got_r && !bvalid;
        if (awvalid && awready) begin
            aw_got_nxt = 1'b1;
            wa_nxt     = awaddr;
        end
        if (wvalid && wready) begin
            w_got_nxt = 1'b1;
            wd_nxt    = wdata;
            ws_nxt    = wstrb;
        end
        if (wr_exec) begin
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = addr_ok(wa_r) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid && bready) begin
            bvalid_nxt = 1'b0;
        end
        awready_nxt = !aw_got_nxt && !bvalid_nxt;
        wready_nxt  = !w_got_nxt && !bvalid_nxt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            wa_r     <= '0;
            wd_r     <= '0;
            ws_r     <= 4'h0;
            awready  <= 1'b0;
            wready   <= 1'b0;
            bvalid   <= 1'b0;
            bresp    <= RESP_OKAY;
        end else begin
            aw_got_r <= aw_got_nxt;
            w_got_r  <= w_got_nxt;
            wa_r     <= wa_nxt;
            wd_r     <= wd_nxt;
            ws_r     <= ws_nxt;
            awready  <= awready_nxt;
            wready   <= wready_nxt;
            bvalid   <= bvalid_nxt;
            bresp    <= bresp_nxt;
        end
    end

    // **********************************************************************
    // Register update
    // **********************************************************************
    always_comb begin
        logic [DATA_W-1:0] wv;
        logic [2:0]        ch;
        wv = '0;
        ch = wa_r[ADDR_W-1:CH_SHIFT];
        ctrl_nxt   = ctrl_r;
        period_nxt = period_r;
        cmp_nxt    = cmp_r;
        dead_nxt   = dead_r;
        // Read-only offsets take the write silently with an OKAY answer
        if (wr_exec && addr_ok(wa_r)) begin
            unique case (wa_r[CH_SHIFT-1:0])
                OFF_CTRL: begin
                    wv = merge({28'h0, ctrl_r[ch]}, wd_r, ws_r);
                    ctrl_nxt[ch] = wv[CTRL_W-1:0];
                end
                OFF_PERIOD: begin
                    wv = merge({16'h0, period_r[ch]}, wd_r, ws_r);
                    period_nxt[ch] = wv[CNT_W-1:0];
                end
                OFF_COMPARE: begin
                    wv = merge({16'h0, cmp_r[ch]}, wd_r, ws_r);
                    cmp_nxt[ch] = wv[CNT_W-1:0];
                end
                OFF_DEAD: begin
                    wv = merge({16'h0, dead_r[ch]}, wd_r, ws_r);
                    dead_nxt[ch] = wv[CNT_W-1:0];
                end
                default: begin
                    wv = '0;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_CH; i++) begin
                ctrl_r[i]   <= CTRL_RST;
                period_r[i] <= PERIOD_RST;
                cmp_r[i]    <= COMPARE_RST;
                dead_r[i]   <= DEAD_RST;
            end
        end else begin
            ctrl_r   <= ctrl_nxt;
            period_r <= period_nxt;
            cmp_r    <= cmp_nxt;
            dead_r   <= dead_nxt;
        end
    end

    // **********************************************************************
    // Read channel
    // **********************************************************************
    tpu_rd_e           rd_state_r;
    tpu_rd_e           rd_state_nxt;
    logic              arready_nxt;
    logic              rvalid_nxt;
    logic [DATA_W-1:0] rdata_nxt;
    logic [1:0]        rresp_nxt;

    always_comb begin
        logic [2:0] rch;
        rch          = araddr[ADDR_W-1:CH_SHIFT];
        rd_state_nxt = rd_state_r;
        arready_nxt  = arready;
        rvalid_nxt   = rvalid;
        rdata_nxt    = rdata;
        rresp_nxt    = rresp;
        unique case (rd_state_r)
            TPU_RD_IDLE: begin
                arready_nxt = 1'b1;
                if (arvalid && arready) begin
                    rd_state_nxt = TPU_RD_RESP;
                    arready_nxt  = 1'b0;
                    rvalid_nxt   = 1'b1;
                    rdata_nxt    = '0;
                    rresp_nxt    = RESP_SLVERR;
                    if (addr_ok(araddr)) begin
                        rresp_nxt = RESP_OKAY;
                        unique case (araddr[CH_SHIFT-1:0])
                            OFF_CTRL:    rdata_nxt = {28'h0, ctrl_r[rch]};
                            OFF_PERIOD:  rdata_nxt = {16'h0, period_r[rch]};
                            OFF_COMPARE: rdata_nxt = {16'h0, cmp_r[rch]};
                            OFF_DEAD:    rdata_nxt = {16'h0, dead_r[rch]};
                            OFF_CAPTURE: rdata_nxt = {16'h0, capture_w[rch]};
                            OFF_COUNT:   rdata_nxt = {16'h0, count_w[rch]};
                            OFF_STATUS:  rdata_nxt = {30'h0, kill_in[rch], halted_w[rch]};
                            default:     rdata_nxt = '0;
                        endcase
                    end
                end
            end
            TPU_RD_RESP: begin
                arready_nxt = 1'b0;
                if (rready) begin
                    rd_state_nxt = TPU_RD_IDLE;
                    rvalid_nxt   = 1'b0;
                    arready_nxt  = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_r <= TPU_RD_IDLE;
            arready    <= 1'b0;
            rvalid     <= 1'b0;
            rdata      <= '0;
            rresp      <= RESP_OKAY;
        end else begin
            rd_state_r <= rd_state_nxt;
            arready    <= arready_nxt;
            rvalid     <= rvalid_nxt;
            rdata      <= rdata_nxt;
            rresp      <= rresp_nxt;
        end
    end

    // **********************************************************************
    // Channels
    // **********************************************************************
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        tpu_channel u_ch (
            .aclk        (aclk),
            .aresetn     (aresetn),
            .enable      (ctrl_r[g][CTRL_EN]),
            .auto_reload (ctrl_r[g][CTRL_RELOAD]),
            .kill_lvl_p  (ctrl_r[g][CTRL_KILL_P]),
            .kill_lvl_n  (ctrl_r[g][CTRL_KILL_N]),
            .period      (period_r[g]),
            .compare     (cmp_r[g]),
            .dead        (dead_r[g]),
            .capture_in  (capture_in[g]),
            .kill_in     (kill_in[g]),
            .count_r     (count_w[g]),
            .capture_r   (capture_w[g]),
            .halted_r    (halted_w[g]),
            .pwm_p_r     (pwm_out[g]),
            .pwm_n_r     (pwm_n_out[g])
        );
    end
endmodule

// ==== verif/tpu_stage_model.sv ====
// Power-stage model: over-current trip feeding kill, shoot-through watch
`timescale 1ns/1ns
module tpu_stage_model
    import tpu_pkg::*;
(
    // Clock
    input  wire logic              aclk,
    // Gate drives from the unit
    input  wire logic [tpu_pkg::NUM_CH-1:0] pwm_p,
    input  wire logic [tpu_pkg::NUM_CH-1:0] pwm_n,
    // Over-current request from the bench
    input  wire logic [tpu_pkg::NUM_CH-1:0] trip,
    // Kill back to the unit, overlap count
    output logic      [tpu_pkg::NUM_CH-1:0] kill,
    output int                              overlaps
);
    import tpu_pkg::*;

    initial begin
        kill = '0;
        overlaps = 0;
    end
    // Sense comparator settles one cycle after the spike
    always @(posedge aclk) begin
        kill <= trip;
        if ((pwm_p & pwm_n) != '0) begin
            overlaps <= overlaps + 1;
        end
    end
endmodule

// ==== verif/tb_timer_counter_pwm_unit.sv ====
// Self-checking bench for the five-channel timer/PWM unit
`timescale 1ns/1ns
module tb_timer_counter_pwm_unit;
    import tpu_pkg::*;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    logic [4:0]  capture_in, kill_in, pwm_out, pwm_n_out, trip;
    int          errors, checks_done, cyc, overlaps, hp, hn;

    tpu_top dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .capture_in, .kill_in, .pwm_out, .pwm_n_out);
    tpu_stage_model stage (.aclk(aclk), .pwm_p(pwm_out), .pwm_n(pwm_n_out), .trip(trip),
        .kill(kill_in), .overlaps(overlaps));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ****************************************
    // Bus tasks and checks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        rs = bresp;
    endtask

    task automatic rd_(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
    endtask

    task automatic watch(input int n);
        hp = 0;
        hn = 0;
        repeat (n) begin
            @(posedge aclk);
            hp += int'(pwm_out[0]);
            hn += int'(pwm_n_out[0]);
        end
    endtask

    task automatic stop_test;
        $display("checks=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles needed
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            stop_test();
        end
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        {capture_in, trip} = '0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd_(8'h00); chk(rd, 32'h0);
        rd_(8'h14); chk(rd, 32'h0);
        rd_(8'h04); chk(rd, 32'h0000FFFF);
        chk(32'({pwm_out, pwm_n_out}), 32'h0);
        rd_(8'hA0); chk(32'(rs), 32'(RESP_SLVERR));
        wr(8'h1C, 32'h1); chk(32'(rs), 32'(RESP_SLVERR));
        $display("test reset done");
        // Each channel halts at its own period
        for (int c = 0; c < 5; c++) begin
            wr(8'(c * 32 + 4), 32'(c + 3));
            wr(8'(c * 32), 32'h1);
        end
        repeat (30) @(posedge aclk);
        capture_in <= 5'h1F;
        @(posedge aclk);
        capture_in <= 5'h00;
        for (int c = 0; c < 5; c++) begin
            rd_(8'(c * 32 + 20)); chk(rd, 32'(c + 3));
            rd_(8'(c * 32 + 24)); chk(rd, 32'h1);
            rd_(8'(c * 32 + 16)); chk(rd, 32'(c + 3));
        end
        wr(8'h14, 32'h0); chk(32'(rs), 32'(RESP_OKAY));
        rd_(8'h14); chk(rd, 32'h3);
        // Only byte lane 1 of channel 1 period may change
        wstrb <= 4'h2;
        wr(8'h24, 32'h0000AB00);
        wstrb <= 4'hF;
        rd_(8'h24);
        chk(rd, 32'h0000AB04);
        $display("test halt and capture done");
        // Reload with duty 5 of 10 and dead band 2
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h9);
        wr(8'h08, 32'h5);
        wr(8'h0C, 32'h2);
        wr(8'h00, 32'h3);
        repeat (30) @(posedge aclk);
        watch(20);
        chk(32'(hp), 32'h6);
        chk(32'(hn), 32'h6);
        chk(32'(overlaps), 32'h0);
        rd_(8'h18); chk(rd, 32'h0);
        $display("test pwm done");
        // Over-current trip: true side low, complement high
        wr(8'h00, 32'hB);
        trip <= 5'h01;
        repeat (4) @(posedge aclk);
        watch(8);
        chk(32'(hp), 32'h0);
        chk(32'(hn), 32'h8);
        rd_(8'h18); chk(rd, 32'h2);
        trip <= 5'h00;
        $display("test kill done");
        stop_test();
    end
endmodule
